// File: hpp_map.svh
// Constants of the host parallel port: widths, timing counts.
// Assumes inclusion by bare name from the package or design file.
`ifndef HPP_MAP_SVH
`define HPP_MAP_SVH
`define HPP_ADDR_W          16
`define HPP_DATA_W          8
`define HPP_LOW_ADDR_W      8
`define HPP_CS_BASE         8'h00
`define HPP_RESET_CYCLES    400
`define HPP_READY_NORMAL    4
`define HPP_READY_EARLY     3
`endif

// File: hpp_pkg.sv
// Types of the host parallel port.
// Assumes hpp_map.svh is on the include path.
`include "hpp_map.svh"
package hpp_pkg;
  typedef enum logic [1:0] {
    HPP_IDLE,
    HPP_WAIT,
    HPP_READY
  } hpp_state_t;

  typedef struct packed {
    logic [1:0]                   rd_sync;
    logic [1:0]                   wr_sync;
    logic                         rd_prev;
    logic                         wr_prev;
    logic                         ale_prev;
    logic [`HPP_LOW_ADDR_W-1:0]   low_addr;
    logic                         cs_latched;
    hpp_state_t                   state;
    logic                         is_read;
    logic [2:0]                   wait_cnt;
    logic                         ready_n;
    logic [`HPP_DATA_W-1:0]       rdata;
    logic                         drive;
    logic                         mem_rd;
    logic                         mem_wr;
    logic [`HPP_ADDR_W-1:0]       mem_addr;
    logic [`HPP_DATA_W-1:0]       mem_wdata;
  } hpp_state_s_t;
endpackage

// File: hpp_port.sv
// Host parallel port: multiplexed synchronous and asynchronous modes.
// Assumes host pins synchronous to clock, strobes resynchronised here, internal memory answers in one cycle.
//
// Overview of operation
// - Latch low address on address-latch falling edge
// - Mux mode: decode chip select from high address
// - Sync mode: read on fall, write on rise
// - Async mode: read on fall, write on rise
// - Ready registered on core clock
// - Ready withdrawn when strobe deasserted
// - Data bus released while read inactive
// - Normal ready about six cycles after strobe
// - Early ready one cycle sooner
// - Names ending _n are active low
`timescale 1ns/1ps
`include "hpp_map.svh"
module hpp_port #(
  parameter int ADDR_W  = `HPP_ADDR_W,
  parameter int DATA_W  = `HPP_DATA_W,
  parameter int LOW_W   = `HPP_LOW_ADDR_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              mux_mode,
  input  wire logic              early_ready,
  input  wire logic              addr_latch,
  input  wire logic [ADDR_W-1:0] host_address_bus,
  input  wire logic              chip_select_n,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  output logic                   ready_out_n,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_wdata,
  input  wire logic [DATA_W-1:0] mem_rdata
);
  // Widths are fixed by the state record; wait counts must fit the 3-bit counter
  if (ADDR_W <= LOW_W || LOW_W < 1 || DATA_W < 1) begin : g_range_check
    $error("hpp_port: unsupported widths");
  end
  if (ADDR_W != `HPP_ADDR_W || DATA_W != `HPP_DATA_W || LOW_W != `HPP_LOW_ADDR_W) begin : g_record_check
    $error("hpp_port: widths differ from the state record");
  end
  if (`HPP_READY_EARLY < 2 || `HPP_READY_NORMAL > 7 || `HPP_READY_EARLY >= `HPP_READY_NORMAL) begin : g_wait_check
    $error("hpp_port: unsupported ready wait counts");
  end

  localparam logic [2:0] NORMAL_WAIT = 3'(`HPP_READY_NORMAL);
  localparam logic [2:0] EARLY_WAIT  = 3'(`HPP_READY_EARLY);
  localparam logic [ADDR_W-LOW_W-1:0] CS_BASE = (ADDR_W-LOW_W)'(`HPP_CS_BASE);

  hpp_pkg::hpp_state_s_t s_reg;
  hpp_pkg::hpp_state_s_t s_next;

  logic rd_s;
  logic wr_s;
  logic rd_fall;
  logic wr_rise;
  logic cs_active;
  logic [ADDR_W-1:0] full_addr;

  // Strobe of the running access seen high again
  function automatic logic strobe_done(input logic is_read, input logic rd_lvl, input logic wr_lvl);
    return is_read ? rd_lvl : wr_lvl;
  endfunction

  assign rd_s    = s_reg.rd_sync[1];
  assign wr_s    = s_reg.wr_sync[1];
  assign rd_fall = s_reg.rd_prev && !rd_s;
  assign wr_rise = !s_reg.wr_prev && wr_s;
  // Mux mode: chip select decoded at latch time; async: pin
  assign cs_active = mux_mode ? s_reg.cs_latched : !chip_select_n;
  assign full_addr = mux_mode ? {host_address_bus[ADDR_W-1:LOW_W], s_reg.low_addr} : host_address_bus;

  always_comb begin
    s_next = s_reg;
    s_next.rd_sync = {s_reg.rd_sync[0], read_strobe_n};
    s_next.wr_sync = {s_reg.wr_sync[0], write_strobe_n};
    s_next.rd_prev = rd_s;
    s_next.wr_prev = wr_s;
    s_next.ale_prev = addr_latch;
    s_next.mem_rd = 1'b0;
    s_next.mem_wr = 1'b0;
    if (s_reg.ale_prev && !addr_latch) begin
      s_next.low_addr   = host_address_bus[LOW_W-1:0];
      s_next.cs_latched = host_address_bus[ADDR_W-1:LOW_W] == CS_BASE;
    end
    if (s_reg.mem_rd) begin
      s_next.rdata = mem_rdata;
    end
    unique case (s_reg.state)
      hpp_pkg::HPP_IDLE: begin
        if (cs_active && rd_fall) begin
          s_next.state    = hpp_pkg::HPP_WAIT;
          s_next.is_read  = 1'b1;
          s_next.mem_rd   = 1'b1;
          s_next.mem_addr = full_addr;
          s_next.wait_cnt = early_ready ? EARLY_WAIT : NORMAL_WAIT;
        end else if (cs_active && wr_rise) begin
          s_next.mem_wr    = 1'b1;
          s_next.mem_addr  = full_addr;
          s_next.mem_wdata = data_in;
        end else if (cs_active && !wr_s && !mux_mode) begin
          s_next.state    = hpp_pkg::HPP_WAIT;
          s_next.is_read  = 1'b0;
          s_next.wait_cnt = early_ready ? EARLY_WAIT : NORMAL_WAIT;
        end
      end
      hpp_pkg::HPP_WAIT: begin
        if (strobe_done(s_reg.is_read, rd_s, wr_s)) begin
          s_next.state = hpp_pkg::HPP_IDLE;
          if (!s_reg.is_read) begin
            s_next.mem_wr    = 1'b1;
            s_next.mem_addr  = full_addr;
            s_next.mem_wdata = data_in;
          end
        end else if (s_reg.wait_cnt <= 3'h2) begin
          s_next.state   = hpp_pkg::HPP_READY;
          s_next.ready_n = 1'b0;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt - 3'h1;
        end
      end
      hpp_pkg::HPP_READY: begin
        if (strobe_done(s_reg.is_read, rd_s, wr_s)) begin
          s_next.state   = hpp_pkg::HPP_IDLE;
          s_next.ready_n = 1'b1;
          if (!s_reg.is_read) begin
            s_next.mem_wr    = 1'b1;
            s_next.mem_addr  = full_addr;
            s_next.mem_wdata = data_in;
          end
        end
      end
    endcase
    s_next.drive = !read_strobe_n && cs_active;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.rd_sync <= 2'h3;
      s_reg.wr_sync <= 2'h3;
      s_reg.rd_prev <= 1'b1;
      s_reg.wr_prev <= 1'b1;
      s_reg.ready_n <= 1'b1;
      s_reg.state   <= hpp_pkg::HPP_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign data_out    = s_reg.rdata;
  assign data_oe     = s_reg.drive && !read_strobe_n;
  assign ready_out_n = s_reg.ready_n;
  assign mem_rd      = s_reg.mem_rd;
  assign mem_wr      = s_reg.mem_wr;
  assign mem_addr    = s_reg.mem_addr;
  assign mem_wdata   = s_reg.mem_wdata;

  ready_release_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_READY && rd_s && s_reg.is_read) |=> ready_out_n)
    else $error("ready not withdrawn after strobe release");
  bus_release_a: assert property (@(posedge clock) disable iff (rst)
    read_strobe_n |-> !data_oe)
    else $error("data bus driven while read inactive");
  read_start_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_IDLE && cs_active && rd_fall) |=> mem_rd)
    else $error("read not started on strobe fall");
  normal_ready_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_IDLE && cs_active && rd_fall && !early_ready) ##1 (!rd_s)[*3]
      |-> ##[0:1] !ready_out_n)
    else $error("normal ready late");
  early_ready_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_IDLE && cs_active && rd_fall && early_ready) ##1 (!rd_s)[*2]
      |-> ##[0:1] !ready_out_n)
    else $error("early ready late");
  ready_registered_a: assert property (@(posedge clock) disable iff (rst)
    $fell(ready_out_n) |-> $past(s_reg.state) == hpp_pkg::HPP_WAIT)
    else $error("ready fell outside wait state");
  addr_latch_a: assert property (@(posedge clock) disable iff (rst)
    ($past(addr_latch) && !addr_latch && s_reg.ale_prev) |=> s_reg.low_addr == $past(host_address_bus[LOW_W-1:0]))
    else $error("low address not latched");
  write_commit_a: assert property (@(posedge clock) disable iff (rst)
    (mux_mode && s_reg.state == hpp_pkg::HPP_IDLE && cs_active && wr_rise && !rd_fall) |=> mem_wr)
    else $error("write not committed on strobe rise");
  // Ready must not open before its window
  normal_not_early_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_IDLE && cs_active && rd_fall && !early_ready) |=> ready_out_n[*3])
    else $error("normal ready too soon");
  early_not_early_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_IDLE && cs_active && rd_fall && early_ready) |=> ready_out_n[*2])
    else $error("early ready too soon");
  write_ready_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_IDLE && cs_active && !wr_s && !mux_mode && !rd_fall && !early_ready)
      ##1 (!wr_s)[*3] |-> ##[0:1] !ready_out_n)
    else $error("write ready late");
  async_commit_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state != hpp_pkg::HPP_IDLE && !s_reg.is_read && wr_s) |=> mem_wr)
    else $error("async write not committed on strobe rise");
  ready_idle_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_IDLE) |-> ready_out_n)
    else $error("ready low while idle");
  no_select_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_IDLE && !cs_active) |=> (!mem_rd && !mem_wr))
    else $error("access started without select");
  ready_hold_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.state == hpp_pkg::HPP_READY && !strobe_done(s_reg.is_read, rd_s, wr_s)) |=> !ready_out_n)
    else $error("ready dropped while strobe active");
  read_capture_a: assert property (@(posedge clock) disable iff (rst)
    s_reg.mem_rd |=> data_out == $past(mem_rdata))
    else $error("read data not captured");
  ale_decode_a: assert property (@(posedge clock) disable iff (rst)
    (s_reg.ale_prev && !addr_latch) |=> s_reg.cs_latched == ($past(host_address_bus[ADDR_W-1:LOW_W]) == CS_BASE))
    else $error("chip select not decoded at latch");
endmodule

// File: hpp_mem_model.sv
// Memory model behind the host port, read answer within the mem_rd cycle.
// Assumes mem_rd and mem_wr are one-cycle pulses on clock.
`timescale 1ns/1ps
module hpp_mem_model (
  input  wire logic        clock,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] cells [256];
  // Inverted data outside mem_rd so a late sample cannot match
  assign mem_rdata = mem_rd ? cells[mem_addr[7:0]] : ~cells[mem_addr[7:0]];
  always_ff @(posedge clock) begin
    if (mem_wr) cells[mem_addr[7:0]] <= mem_wdata;
  end
endmodule

// File: tb.sv
// Testbench of the host port in both bus modes.
// Assumes hpp_port and hpp_mem_model are compiled first.
`timescale 1ns/1ps
`include "hpp_map.svh"
module tb;
  logic        clock = 0, rst = 1, mux_mode = 0, early_ready = 0, addr_latch = 0;
  logic        chip_select_n = 1, read_strobe_n = 1, write_strobe_n = 1;
  logic [15:0] host_address_bus = 16'h0000, mem_addr;
  logic [7:0]  data_in = 8'h00, data_out, mem_wdata, mem_rdata, rd;
  logic        data_oe, ready_out_n, mem_rd, mem_wr;
  int          failures = 0, total_checks = 0, cycles = 0, cn, ce, cx;
  always #5 clock = ~clock;
  // Core clock only; the port has no other clock input
  hpp_port u_dut (.clock(clock), .rst(rst), .mux_mode(mux_mode), .early_ready(early_ready),
    .addr_latch(addr_latch), .host_address_bus(host_address_bus), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ready_out_n(ready_out_n), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  hpp_mem_model u_mem (.clock(clock), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One host access; cyc counts strobe fall to ready low
  task automatic acc(input logic r, input logic cs_n, input logic [15:0] a, input logic [7:0] d,
                     output int cyc, output logic [7:0] q);
    @(negedge clock);
    host_address_bus = a;
    data_in = d;
    if (mux_mode) begin
      addr_latch = 1;
      repeat (3) @(negedge clock);
      addr_latch = 0;
      repeat (3) @(negedge clock);
    end
    chip_select_n = cs_n;
    if (r) read_strobe_n = 0;
    else write_strobe_n = 0;
    cyc = 0;
    while (ready_out_n !== 1'b0 && cyc < 12) begin
      @(negedge clock);
      cyc++;
    end
    q = data_out;
    if (r && cyc < 12) check(data_oe, 1'b1, "drive while reading");
    read_strobe_n = 1;
    write_strobe_n = 1;
    @(negedge clock);
    check(data_oe, 1'b0, "bus released");
    repeat (4) @(negedge clock);
    check(ready_out_n, 1'b1, "ready withdrawn");
    chip_select_n = 1;
    repeat (4) @(negedge clock);
  endtask
  task automatic async_rw;
    // Ready windows counted in falling edges after the strobe falls
    acc(0, 0, 16'h0012, 8'hA5, cx, rd);
    check(8'(cx >= 5 && cx <= 7), 8'h01, "write ready delay");
    acc(1, 0, 16'h0012, 8'h00, cn, rd);
    check(rd, 8'hA5, "async read back");
    check(8'(cn >= 5 && cn <= 7), 8'h01, "normal ready delay");
    early_ready = 1;
    acc(1, 0, 16'h0012, 8'h00, ce, rd);
    check(rd, 8'hA5, "early read back");
    check(8'(ce >= 4 && ce <= 6), 8'h01, "early ready window");
    check(8'(ce), 8'(cn - 1), "early ready one sooner");
    early_ready = 0;
    acc(1, 1, 16'h0012, 8'h00, cx, rd);
    check(8'(cx), 8'h0C, "no ready without select");
  endtask
  task automatic mux_rw;
    mux_mode = 1;
    acc(0, 0, 16'h0034, 8'h5A, cx, rd);
    acc(0, 0, 16'h0134, 8'hFF, cx, rd);
    acc(1, 0, 16'h0034, 8'h00, cx, rd);
    check(rd, 8'h5A, "mux latch and decode");
    mux_mode = 0;
  endtask
  // Long reset in mid-run, then one read to show the port works again
  task automatic mid_reset;
    @(negedge clock);
    rst = 1;
    repeat (`HPP_RESET_CYCLES) @(negedge clock);
    check(ready_out_n, 1'b1, "ready high in reset");
    check(mem_wr, 1'b0, "no write in reset");
    rst = 0;
    acc(1, 0, 16'h0012, 8'h00, cn, rd);
    check(rd, 8'hA5, "read after reset");
    check(8'(cn >= 5 && cn <= 7), 8'h01, "ready delay after reset");
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    repeat (5) @(negedge clock);
    rst = 0;
    check(ready_out_n, 1'b1, "ready idle after reset");
    async_rw;
    mux_rw;
    mid_reset;
    wrap_up;
  end
endmodule
